// file: src/uec_device.sv
`timescale 1ns/1ps
// How it works
// RQ1 - endpoint reset clears state, keeps configuration
// RQ2 - bus reset keeps endpoint interrupt flags
// RQ3 - toggle reset set clears data toggle
// RQ4 - software releases endpoint reset before use
// RQ5 - disabled endpoint held inactive and reset
// RQ6 - no ack until configuration valid
// RQ7 - address filter, default address zero
// RQ8 - address first, enable after zero-length IN
// RQ9 - address cleared on every reset
// RQ10 - idle 3 ms sets suspend flag
// RQ11 - activity sets bus_activity_flag; flags exclude each other
// RQ12 - detach resets high, removes pull-up
// RQ13 - remote wake after suspend, 5 ms idle
// RQ14 - resume sets flag, clears request, end flag
// RQ15 - stall answers IN and non-retry OUT, sets stalled flag
// RQ16 - setup acked on stalled control endpoint
// RQ17 - retry wins over stall
// RQ18 - setup always acked, no out flag
// RQ19 - bank control, rw-allowed read zero on control
// RQ20 - first status token naked, IN data dropped
// RQ21 - out retry acked; zero length clears count
// RQ22 - setup overrides, clears flags, resets FIFO
// RQ23 - separate set and clear strobes per flag
module uec_device import uec_pkg::*; #(
	parameter int SUSPEND_CYCLES = SUSPEND_CYC,
	parameter int RESUME_IDLE_CYCLES = RESUME_IDLE_CYC,
	parameter int RESUME_DRIVE_CYCLES = RESUME_DRIVE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// link
	uec_link_if.device link,
	// controller control
	input wire logic controller_enable_bit,
	input wire logic usb_bus_reset,
	// device control writes
	input wire logic addr_wr,
	input wire logic [6:0] addr_wdata,
	input wire logic addr_en_wdata,
	input wire logic detach_wr,
	input wire logic detach_wdata,
	input wire logic remote_wake_request_set,
	input wire logic [3:0] glob_flag_clear,
	// endpoint control, one entry per endpoint
	input wire logic [EP_NUM-1:0] endpoint_enable_bit,
	input wire logic [EP_NUM-1:0] endpoint_reset_bit,
	input wire logic [EP_NUM-1:0] ep_is_control,
	input wire logic [EP_NUM-1:0] bank_allocate,
	input wire logic [EP_NUM-1:0][1:0] bank_count,
	input wire logic [EP_NUM-1:0][10:0] endpoint_size,
	input wire logic [EP_NUM-1:0] toggle_reset_set,
	input wire logic [EP_NUM-1:0] stall_request_set,
	input wire logic [EP_NUM-1:0] stall_request_clear,
	input wire logic [EP_NUM-1:0] in_ready_set,
	input wire logic [EP_NUM-1:0] bank_control_set,
	input wire logic [EP_NUM-1:0][4:0] ep_flag_clear,
	// status
	output logic [6:0] device_address_field,
	output logic address_enable_bit,
	output logic detach_q,
	output logic remote_wake_request,
	output logic [3:0] glob_flags_q,
	output logic [EP_NUM-1:0] config_valid_flag,
	output logic [EP_NUM-1:0] toggle_reset_bit,
	output logic [EP_NUM-1:0] data_toggle_sequence,
	output logic [EP_NUM-1:0] stall_request_bit,
	output logic [EP_NUM-1:0][4:0] ep_flags_q,
	output logic [EP_NUM-1:0] bank_control_bit,
	output logic [EP_NUM-1:0] rw_allowed_bit,
	output logic [EP_NUM-1:0][10:0] byte_count_q,
	output logic [EP_NUM-1:0] endpoint_interrupt
);
	// ep flag bits: 0 setup, 1 out, 2 in ready, 3 in naked, 4 stalled
	// glob flag bits: 0 suspend, 1 activity, 2 upstream resume, 3 resume end

	// ****************************************
	// bus line conditioning
	// ****************************************
	logic [2:0] idle_sync_q;
	logic idle_s;
	logic [2:0] rend_sync_q;
	logic rend_s;
	logic rend_prev_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			idle_sync_q <= 3'h7;
			rend_sync_q <= 3'h0;
		end else if (ce) begin
			idle_sync_q <= {idle_sync_q[1:0], link.bus_idle};
			rend_sync_q <= {rend_sync_q[1:0], link.host_resume_end};
		end
	end
	// a change counts once stage two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			idle_s <= 1'b1;
			rend_s <= 1'b0;
			rend_prev_q <= 1'b0;
		end else if (ce) begin
			if (idle_sync_q[1] == idle_sync_q[2]) idle_s <= idle_sync_q[2];
			if (rend_sync_q[1] == rend_sync_q[2]) rend_s <= rend_sync_q[2];
			rend_prev_q <= rend_s;
		end
	end

	// ****************************************
	// two-entry token buffer
	// ****************************************
	logic [13:0] buf_q [2];
	logic [1:0] buf_cnt_q;
	logic buf_wp_q, buf_rp_q;
	wire buf_in_ok = link.tok_valid && (buf_cnt_q != 2'd2);
	wire buf_has = buf_cnt_q != 2'd0;
	wire [13:0] head = buf_q[buf_rp_q];
	wire buf_pop = buf_has;
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_cnt_q <= 2'd0;
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
		end else if (ce) begin
			if (buf_in_ok) begin
				// spare low bit fills the word out to the field slices below
				buf_q[buf_wp_q] <= {link.tok_kind, link.tok_addr, link.tok_ep, link.tok_zlp, link.tok_retry, 1'b0};
				buf_wp_q <= ~buf_wp_q;
			end
			if (buf_pop) buf_rp_q <= ~buf_rp_q;
			buf_cnt_q <= buf_cnt_q + 2'(buf_in_ok) - 2'(buf_pop);
		end
	end
	assign link.tok_ready = buf_cnt_q != 2'd2;
	wire uec_tok_e h_kind = uec_tok_e'(head[13:12]);
	wire [6:0] h_addr = head[11:5];
	wire [1:0] h_ep = head[4:3];
	wire h_zlp = head[2];
	wire h_retry = head[1];

	// ****************************************
	// address, detach, suspend and resume
	// ****************************************
	wire dev_rst = rst || !controller_enable_bit || usb_bus_reset;
	wire [6:0] live_addr = address_enable_bit ? device_address_field : DEFAULT_ADDR; // [RQ7]
	wire addr_hit = h_addr == live_addr; // [RQ7]
	logic [31:0] idle_cnt_q;
	logic [31:0] drive_cnt_q;
	logic drive_q;
	wire activity = !idle_s;
	wire suspend_flag_set = idle_s && idle_cnt_q == 32'(SUSPEND_CYCLES - 1);
	wire rsm_start = remote_wake_request && !drive_q && idle_s && idle_cnt_q >= 32'(RESUME_IDLE_CYCLES - 1); // [RQ13]
	wire rsm_end = drive_q && drive_cnt_q == 32'(RESUME_DRIVE_CYCLES - 1);
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			device_address_field <= DEFAULT_ADDR; // [RQ9]
			address_enable_bit <= 1'b0; // [RQ9]
		end else if (ce && addr_wr) begin
			device_address_field <= addr_wdata;
			address_enable_bit <= addr_en_wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			detach_q <= DETACH_RST; // [RQ12]
			link.pullup_en <= 1'b0;
			remote_wake_request <= 1'b0;
			glob_flags_q <= 4'h0;
			idle_cnt_q <= 32'h0;
			drive_cnt_q <= 32'h0;
			drive_q <= 1'b0;
			link.dev_resume_drive <= 1'b0;
		end else if (ce) begin
			if (detach_wr) detach_q <= detach_wdata;
			link.pullup_en <= !detach_q; // [RQ12]
			idle_cnt_q <= (activity || drive_q) ? 32'h0 : idle_cnt_q + 32'h1;
			if (remote_wake_request_set && glob_flags_q[0]) remote_wake_request <= 1'b1; // [RQ13]
			else if (rsm_end) remote_wake_request <= 1'b0; // [RQ14]
			drive_q <= rsm_start || (drive_q && !rsm_end);
			link.dev_resume_drive <= rsm_start || (drive_q && !rsm_end);
			drive_cnt_q <= drive_q ? drive_cnt_q + 32'h1 : 32'h0;
			// set wins over software clear
			glob_flags_q[0] <= (suspend_flag_set) || (glob_flags_q[0] && !glob_flag_clear[0] && !(activity && !drive_q)
				&& !rsm_start); // [RQ10] [RQ11] [RQ14]
			glob_flags_q[1] <= (activity && !drive_q) || (glob_flags_q[1] && !glob_flag_clear[1] && !suspend_flag_set); // [RQ11]
			glob_flags_q[2] <= rsm_start || (glob_flags_q[2] && !glob_flag_clear[2]); // [RQ14]
			glob_flags_q[3] <= (rend_s && !rend_prev_q) || (glob_flags_q[3] && !glob_flag_clear[3]); // [RQ14]
		end
	end

	// ****************************************
	// endpoints
	// ****************************************
	function automatic logic cfg_fits(input logic [10:0] sz, input logic [1:0] bk);
		logic [15:0] total;
		total = 16'(sz) * 16'(bk);
		cfg_fits = sz != 11'h0 && sz <= 11'(EP_MAX_SIZE) && bk != 2'd0 && total <= 16'(DPRAM_BYTES);
	endfunction

	uec_stage_e stage_q [EP_NUM];
	uec_hs_e ans_d;
	logic ans_v_d;
	always_comb begin
		ans_d = UEC_HS_NONE;
		ans_v_d = 1'b0;
		if (buf_pop && addr_hit && h_kind != UEC_TOK_SOF) begin
			ans_v_d = 1'b1;
			if (!config_valid_flag[h_ep] || !endpoint_enable_bit[h_ep] || endpoint_reset_bit[h_ep]) ans_d = UEC_HS_NONE; // [RQ6]
			else if (h_kind == UEC_TOK_SETUP) ans_d = UEC_HS_ACK; // [RQ18] [RQ16]
			else if (h_retry && h_kind == UEC_TOK_OUT) ans_d = UEC_HS_ACK; // [RQ21] [RQ17]
			else if (stall_request_bit[h_ep]) ans_d = UEC_HS_STALL; // [RQ15]
			else if (h_kind == UEC_TOK_IN && stage_q[h_ep] == UEC_ST_STATUS) ans_d = UEC_HS_NAK; // [RQ20]
			else if (h_kind == UEC_TOK_IN) ans_d = ep_flags_q[h_ep][2] ? UEC_HS_NAK : UEC_HS_DATA;
			else ans_d = UEC_HS_ACK;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			link.ans_valid <= 1'b0;
			link.ans_hs <= UEC_HS_NONE;
		end else if (ce) begin
			link.ans_valid <= ans_v_d && ans_d != UEC_HS_NONE;
			link.ans_hs <= ans_d;
		end
	end

	for (genvar e = 0; e < EP_NUM; e++) begin : g_ep
		wire hit = buf_pop && addr_hit && h_ep == 2'(e) && ans_d != UEC_HS_NONE;
		wire is_setup = hit && h_kind == UEC_TOK_SETUP;
		wire is_out = hit && h_kind == UEC_TOK_OUT;
		wire is_in = hit && h_kind == UEC_TOK_IN;
		wire stalled = hit && ans_d == UEC_HS_STALL;
		wire ep_rst = rst || endpoint_reset_bit[e] || !endpoint_enable_bit[e]; // [RQ1] [RQ5] [RQ4]
		always_ff @(posedge clk) begin
			if (rst || !endpoint_enable_bit[e]) begin
				config_valid_flag[e] <= 1'b0;
				data_toggle_sequence[e] <= 1'b0; // [RQ5]
			end else if (ce) begin
				config_valid_flag[e] <= bank_allocate[e] && cfg_fits(endpoint_size[e], bank_count[e]); // [RQ6]
				if (toggle_reset_bit[e] || (usb_bus_reset && e == 0)) data_toggle_sequence[e] <= 1'b0; // [RQ3]
				else if (hit && ans_d != UEC_HS_STALL && ans_d != UEC_HS_NAK) data_toggle_sequence[e] <= ~data_toggle_sequence[e];
			end
		end
		always_ff @(posedge clk) begin
			if (ep_rst) begin
				// data toggle and configuration lie outside this reset
				stage_q[e] <= UEC_ST_IDLE; // [RQ1]
				toggle_reset_bit[e] <= 1'b0;
				stall_request_bit[e] <= 1'b0;
				ep_flags_q[e] <= 5'h00;
				bank_control_bit[e] <= 1'b0;
				rw_allowed_bit[e] <= 1'b0;
				byte_count_q[e] <= 11'h000;
				endpoint_interrupt[e] <= 1'b0;
			end else if (ce) begin
				// usb_bus_reset deliberately not used here [RQ2]
				toggle_reset_bit[e] <= toggle_reset_set[e]; // [RQ3] [RQ23]
				if (is_setup) stall_request_bit[e] <= 1'b0; // [RQ16] [RQ22]
				else if (stall_request_set[e]) stall_request_bit[e] <= 1'b1; // [RQ23]
				else if (stall_request_clear[e]) stall_request_bit[e] <= 1'b0; // [RQ15]
				if (is_setup) begin
					ep_flags_q[e] <= 5'b00001; // [RQ18] [RQ22]
					byte_count_q[e] <= 11'h000; // [RQ22]
					stage_q[e] <= UEC_ST_DATA_IN;
				end else begin
					ep_flags_q[e][0] <= ep_flags_q[e][0] && !ep_flag_clear[e][0];
					ep_flags_q[e][1] <= (is_out && !stalled) || (ep_flags_q[e][1] && !ep_flag_clear[e][1]); // [RQ15]
					// in-ready clear ignored while in status stage
					ep_flags_q[e][2] <= (is_out && h_retry) || in_ready_set[e] || (ep_flags_q[e][2]
						&& !(ep_flag_clear[e][2] && stage_q[e] != UEC_ST_STATUS)); // [RQ20] [RQ21] [RQ23]
					ep_flags_q[e][3] <= (is_in && ans_d == UEC_HS_NAK) || (ep_flags_q[e][3] && !ep_flag_clear[e][3]);
					ep_flags_q[e][4] <= stalled || (ep_flags_q[e][4] && !ep_flag_clear[e][4]); // [RQ15]
					if (is_out && h_zlp) byte_count_q[e] <= 11'h000; // [RQ21]
					if (is_in && stage_q[e] == UEC_ST_DATA_IN && ep_is_control[e] && h_zlp) stage_q[e] <= UEC_ST_STATUS;
					else if (is_out && stage_q[e] == UEC_ST_STATUS) stage_q[e] <= UEC_ST_WAIT_SETUP; // [RQ22]
				end
				endpoint_interrupt[e] <= stalled || (|ep_flags_q[e]); // [RQ15]
				bank_control_bit[e] <= ep_is_control[e] ? 1'b0 : (bank_control_set[e] || bank_control_bit[e]); // [RQ19]
				rw_allowed_bit[e] <= ep_is_control[e] ? 1'b0 : byte_count_q[e] != 11'h000; // [RQ19]
			end
		end
	end
endmodule

// file: src/uec_pkg.sv
package uec_pkg;
	// endpoint configuration limits
	localparam int EP_NUM = 4;
	localparam int EP_MAX_SIZE = 1024;
	localparam int DPRAM_BYTES = 4096;
	localparam logic [6:0] DEFAULT_ADDR = 7'h00;
	// clock rate, bus idle and resume drive times
	localparam int CLK_MHZ = 100;
	localparam int SUSPEND_MS = 3;
	localparam int RESUME_IDLE_MS = 5;
	localparam int RESUME_DRIVE_US = 1000;
	localparam int SUSPEND_CYC = SUSPEND_MS * 1000 * CLK_MHZ;
	localparam int RESUME_IDLE_CYC = RESUME_IDLE_MS * 1000 * CLK_MHZ;
	localparam int RESUME_DRIVE_CYC = RESUME_DRIVE_US * CLK_MHZ;
	// reset values
	localparam logic DETACH_RST = 1'b1;
	// host token kinds
	typedef enum logic [1:0] {
		UEC_TOK_SETUP = 2'b00,
		UEC_TOK_OUT = 2'b01,
		UEC_TOK_IN = 2'b10,
		UEC_TOK_SOF = 2'b11
	} uec_tok_e;
	// device answers
	typedef enum logic [2:0] {
		UEC_HS_NONE = 3'b000,
		UEC_HS_ACK = 3'b001,
		UEC_HS_NAK = 3'b010,
		UEC_HS_STALL = 3'b011,
		UEC_HS_DATA = 3'b100
	} uec_hs_e;
	// control transfer stages
	typedef enum logic [1:0] {
		UEC_ST_IDLE = 2'b00,
		UEC_ST_DATA_IN = 2'b01,
		UEC_ST_STATUS = 2'b10,
		UEC_ST_WAIT_SETUP = 2'b11
	} uec_stage_e;
endpackage

// file: src/uec_link_if.sv
`timescale 1ns/1ps
interface uec_link_if;
	import uec_pkg::*;
	// token from host
	logic tok_valid;
	logic tok_ready;
	uec_tok_e tok_kind;
	logic [6:0] tok_addr;
	logic [1:0] tok_ep;
	logic tok_zlp;
	logic tok_retry;
	// answer from device
	logic ans_valid;
	uec_hs_e ans_hs;
	// bus line state
	logic bus_idle;
	logic host_resume_end;
	logic dev_resume_drive;
	logic pullup_en;
	modport device (input tok_valid, tok_kind, tok_addr, tok_ep, tok_zlp, tok_retry, bus_idle, host_resume_end,
		output tok_ready, ans_valid, ans_hs, dev_resume_drive, pullup_en);
	modport host (output tok_valid, tok_kind, tok_addr, tok_ep, tok_zlp, tok_retry, bus_idle, host_resume_end,
		input tok_ready, ans_valid, ans_hs, dev_resume_drive, pullup_en);
endinterface

// file: src/uec_host.sv
`timescale 1ns/1ps
module uec_host import uec_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// link
	uec_link_if.host link,
	// user requests
	input wire logic req_valid,
	input wire uec_tok_e req_kind,
	input wire logic [6:0] req_addr,
	input wire logic [1:0] req_ep,
	input wire logic req_zlp,
	input wire logic req_retry,
	input wire logic req_idle,
	input wire logic req_resume_end,
	// user view
	output logic req_ready,
	output logic ans_seen,
	output uec_hs_e ans_hs_q,
	output logic remote_resume_seen,
	output logic attached
);
	// host drives tokens and line state only; software-side ordering of address and enable is not a link matter
	always_ff @(posedge clk) begin
		if (rst) begin
			link.tok_valid <= 1'b0;
			link.tok_kind <= UEC_TOK_SOF;
			link.tok_addr <= 7'h00;
			link.tok_ep <= 2'd0;
			link.tok_zlp <= 1'b0;
			link.tok_retry <= 1'b0;
			link.bus_idle <= 1'b1;
			link.host_resume_end <= 1'b0;
			req_ready <= 1'b0;
			ans_seen <= 1'b0;
			ans_hs_q <= UEC_HS_NONE;
			remote_resume_seen <= 1'b0;
			attached <= 1'b0;
		end else if (ce) begin
			if (!link.tok_valid || link.tok_ready) begin
				link.tok_valid <= req_valid;
				link.tok_kind <= req_kind;
				link.tok_addr <= req_addr;
				link.tok_ep <= req_ep;
				link.tok_zlp <= req_zlp;
				link.tok_retry <= req_retry;
			end
			req_ready <= !link.tok_valid || link.tok_ready;
			link.bus_idle <= req_idle;
			link.host_resume_end <= req_resume_end;
			ans_seen <= link.ans_valid;
			ans_hs_q <= link.ans_hs;
			remote_resume_seen <= link.dev_resume_drive;
			attached <= link.pullup_en;
		end
	end
endmodule

// file: bench/uec_link_properties.sv
`timescale 1ns/1ps
module uec_link_checker import uec_pkg::*; #(
	parameter int RESUME_DRIVE_CYCLES = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// token
	input wire logic tok_valid,
	input wire logic tok_ready,
	input wire uec_tok_e tok_kind,
	input wire logic tok_retry,
	// answer and line state
	input wire logic ans_valid,
	input wire uec_hs_e ans_hs,
	input wire logic bus_idle,
	input wire logic dev_resume_drive,
	input wire logic pullup_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire take = tok_valid && tok_ready;
	logic [15:0] drv_q;
	always_ff @(posedge clk) begin
		drv_q <= (rst || !dev_resume_drive) ? 16'h0 : drv_q + 16'h1;
	end
	property p_ans_kind; ans_valid |-> ans_hs != UEC_HS_NONE; endproperty
	a_ans_kind: assert property (p_ans_kind) else $error("answer strobe without handshake");
	property p_ans_cause; ans_valid |-> $past(take, 2) || $past(take, 3); endproperty
	a_ans_cause: assert property (p_ans_cause) else $error("answer without token");
	property p_setup_ack; ans_valid && $past(take, 2) && $past(tok_kind, 2) == UEC_TOK_SETUP |-> ans_hs == UEC_HS_ACK;
	endproperty
	a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
	property p_retry_first; ans_valid && $past(take, 2) && $past(tok_retry, 2) |-> ans_hs != UEC_HS_STALL; endproperty
	a_retry_first: assert property (p_retry_first) else $error("stall sent on retry");
	property p_sof_quiet; take && tok_kind == UEC_TOK_SOF |-> ##2 !ans_valid; endproperty
	a_sof_quiet: assert property (p_sof_quiet) else $error("frame start answered");
	property p_hold; tok_valid && !tok_ready |=> tok_valid && $stable(tok_kind); endproperty
	a_hold: assert property (p_hold) else $error("token dropped before taken");
	property p_resume_idle; $rose(dev_resume_drive) |-> $past(bus_idle, 1) && $past(bus_idle, 4); endproperty
	a_resume_idle: assert property (p_resume_idle) else $error("resume on busy bus");
	property p_resume_len; $fell(dev_resume_drive) |-> drv_q == RESUME_DRIVE_CYCLES; endproperty
	a_resume_len: assert property (p_resume_len) else $error("resume drive length wrong");
	property p_pullup_rst; $past(rst) |-> !pullup_en; endproperty
	a_pullup_rst: assert property (p_pullup_rst) else $error("pull-up on after reset");
	c_setup: cover property (take && tok_kind == UEC_TOK_SETUP);
	c_stall: cover property (ans_valid && ans_hs == UEC_HS_STALL);
	c_resume: cover property ($rose(dev_resume_drive));
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench import uec_pkg::*;;
	// ****************
	// signals
	// ****************
	logic clk = 0, rst = 1, ce = 1, controller_enable_bit = 1, usb_bus_reset = 0, addr_wr = 0, addr_en_wdata = 0;
	logic detach_wr = 0, detach_wdata = 0, remote_wake_request_set = 0, address_enable_bit, detach_q;
	logic remote_wake_request, req_valid = 0, req_zlp = 0, req_retry = 0, req_idle = 0, req_resume_end = 0;
	logic req_ready, ans_seen, remote_resume_seen, attached;
	logic [6:0] addr_wdata = 0, device_address_field, req_addr = 0;
	logic [1:0] req_ep = 0;
	logic [3:0] glob_flag_clear = 0, glob_flags_q;
	logic [EP_NUM-1:0] endpoint_enable_bit = 0, endpoint_reset_bit = 0, ep_is_control = 4'h1, bank_allocate = 4'hF;
	logic [EP_NUM-1:0] toggle_reset_set = 0, stall_request_set = 0, stall_request_clear = 0, in_ready_set = 0;
	logic [EP_NUM-1:0] bank_control_set = 0, config_valid_flag, toggle_reset_bit, data_toggle_sequence;
	logic [EP_NUM-1:0] stall_request_bit, bank_control_bit, rw_allowed_bit, endpoint_interrupt;
	logic [EP_NUM-1:0][1:0] bank_count = {4{2'h1}};
	logic [EP_NUM-1:0][10:0] endpoint_size = {11'h040, 11'h040, 11'h7FF, 11'h040}, byte_count_q;
	logic [EP_NUM-1:0][4:0] ep_flag_clear = '0, ep_flags_q;
	uec_tok_e req_kind = UEC_TOK_SOF;
	uec_hs_e ans_hs_q;
	logic [31:0] seed = 32'h6A2E;
	int n_mismatch = 0, compares = 0, m_addr = 0, i;
	int m_ok[EP_NUM] = '{0, 0, 0, 0};
	int m_stall[EP_NUM] = '{0, 0, 0, 0};
	int m_sts[EP_NUM] = '{0, 0, 0, 0};
	uec_link_if link();
	uec_device #(.SUSPEND_CYCLES(50), .RESUME_IDLE_CYCLES(80), .RESUME_DRIVE_CYCLES(10)) uec_device_inst (.link, .*);
	uec_host uec_host_inst (.link, .*);
	uec_link_checker #(.RESUME_DRIVE_CYCLES(10)) uec_link_checker_inst (.clk, .rst, .tok_valid(link.tok_valid),
		.tok_ready(link.tok_ready), .tok_kind(link.tok_kind), .tok_retry(link.tok_retry), .ans_valid(link.ans_valid),
		.ans_hs(link.ans_hs), .bus_idle(link.bus_idle), .dev_resume_drive(link.dev_resume_drive),
		.pullup_en(link.pullup_en));
	// ****************
	// helpers
	// ****************
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// reference answer, updates stall state the way a setup does
	function automatic uec_hs_e exp_hs(uec_tok_e k, int a, int e, bit r);
		if (k == UEC_TOK_SOF || a != m_addr || m_ok[e] == 0) return UEC_HS_NONE;
		if (k == UEC_TOK_SETUP) begin
			m_stall[e] = 0;
			m_sts[e] = 0;
			return UEC_HS_ACK;
		end
		if (k == UEC_TOK_OUT) m_sts[e] = 0;
		if (k == UEC_TOK_OUT && r) return UEC_HS_ACK;
		if (m_stall[e] != 0) return UEC_HS_STALL;
		if (k == UEC_TOK_OUT) return UEC_HS_ACK;
		// control read: a zero-length IN opens the status stage, the next IN is refused
		if (m_sts[e] != 0) return UEC_HS_NAK;
		if (e == 0 && req_zlp) m_sts[e] = 1;
		return UEC_HS_DATA;
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tok(uec_tok_e k, logic [6:0] a, logic [1:0] e, logic r);
		uec_hs_e x;
		uec_hs_e got;
		int n;
		x = exp_hs(k, a, e, r);
		got = UEC_HS_NONE;
		n = 0;
		req_kind = k;
		req_addr = a;
		req_ep = e;
		req_retry = r;
		req_valid = 1;
		do @(negedge clk); while (req_ready !== 1'b1 && ++n < 20);
		@(posedge clk);
		#1 req_valid = 0;
		repeat (8) begin
			@(negedge clk);
			if (link.ans_valid === 1'b1) got = link.ans_hs;
		end
		chk(got, x);
		step(1);
	endtask
	task automatic finish_test();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#80000;
		n_mismatch++;
		finish_test();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		step(3);
		rst = 0;
		step(1);
		chk(detach_q, 1);
		chk(link.pullup_en, 0);
		chk(device_address_field, 0);
		endpoint_enable_bit = 4'hB;
		m_ok = '{1, 0, 0, 1};
		detach_wdata = 0;
		detach_wr = 1;
		step(1);
		detach_wr = 0;
		step(3);
		chk(config_valid_flag[0], 1);
		chk(config_valid_flag[1], 0);
		chk(link.pullup_en, 1);
		chk(attached, 1);
		for (i = 0; i < EP_NUM; i++) tok(UEC_TOK_SETUP, 7'h00, 2'(i), 0);
		chk(ep_flags_q[0][1:0], 2'h1);
		tok(UEC_TOK_SOF, 7'h00, 2'h0, 0);
		repeat (3) tok(UEC_TOK_OUT, 7'(rnd() % 32'h7E + 32'h1), 2'h0, 0);
		addr_wdata = 7'h2A;
		addr_wr = 1;
		step(1);
		addr_wr = 0;
		tok(UEC_TOK_OUT, 7'h00, 2'h0, 0);
		req_zlp = 1;
		tok(UEC_TOK_IN, 7'h00, 2'h0, 0);
		tok(UEC_TOK_IN, 7'h00, 2'h0, 0);
		req_zlp = 0;
		addr_en_wdata = 1;
		addr_wr = 1;
		step(1);
		addr_wr = 0;
		m_addr = 42;
		tok(UEC_TOK_OUT, 7'h00, 2'h0, 0);
		tok(UEC_TOK_OUT, 7'h2A, 2'h0, 0);
		usb_bus_reset = 1;
		step(2);
		usb_bus_reset = 0;
		m_addr = 0;
		step(2);
		chk({address_enable_bit, device_address_field}, 0);
		chk(ep_flags_q[0][0], 1);
		stall_request_set = 4'h9;
		m_stall = '{1, 0, 0, 1};
		step(1);
		stall_request_set = 0;
		tok(UEC_TOK_OUT, 7'h00, 2'h0, 0);
		chk({ep_flags_q[0][4], endpoint_interrupt[0]}, 2'h3);
		tok(UEC_TOK_OUT, 7'h00, 2'h0, 1);
		tok(UEC_TOK_SETUP, 7'h00, 2'h0, 0);
		chk({stall_request_bit[0], ep_flags_q[0][4]}, 0);
		stall_request_clear[3] = 1;
		m_stall[3] = 0;
		step(1);
		stall_request_clear = 0;
		tok(UEC_TOK_OUT, 7'h00, 2'h3, 0);
		tok(UEC_TOK_OUT, 7'h00, 2'h0, 0);
		chk(data_toggle_sequence[0], 1);
		toggle_reset_set[0] = 1;
		ep_flag_clear[3] = 5'h1F;
		bank_control_set = 4'h9;
		step(1);
		chk(toggle_reset_bit[0], 1);
		toggle_reset_set = 0;
		ep_flag_clear = '0;
		bank_control_set = 0;
		step(1);
		chk(data_toggle_sequence[0], 0);
		chk({ep_flags_q[3], ep_flags_q[0][0]}, 1);
		chk({bank_control_bit[3], bank_control_bit[0], rw_allowed_bit[0]}, 3'h4);
		endpoint_reset_bit[0] = 1;
		m_ok[0] = 0;
		step(2);
		chk({config_valid_flag[0], ep_flags_q[0]}, 6'h20);
		tok(UEC_TOK_SETUP, 7'h00, 2'h0, 0);
		endpoint_reset_bit = 0;
		req_idle = 1;
		for (i = 0; i < 200 && glob_flags_q[0] !== 1'b1; i++) step(1);
		chk(glob_flags_q[1:0], 2'h1);
		remote_wake_request_set = 1;
		step(1);
		remote_wake_request_set = 0;
		for (i = 0; i < 300 && link.dev_resume_drive !== 1'b1; i++) step(1);
		step(3);
		chk({remote_resume_seen, link.dev_resume_drive, glob_flags_q[2], glob_flags_q[0]}, 4'hE);
		for (i = 0; i < 50 && remote_wake_request !== 1'b0; i++) step(1);
		chk(remote_wake_request, 0);
		req_resume_end = 1;
		// host register plus three-stage filter and edge detector: about six cycles
		step(8);
		req_resume_end = 0;
		chk(glob_flags_q[3], 1);
		req_idle = 0;
		step(8);
		chk(glob_flags_q[1:0], 2'h2);
		finish_test();
	end
endmodule
